/* rtl/spp_pkg.sv */
// Package of offsets, field positions, reset values and timing for the SFR power, status and pulse block
package spp_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 8;

  localparam logic [3:0] OFS_POWER      = 4'h0;
  localparam logic [3:0] OFS_STATUS     = 4'h1;
  localparam logic [3:0] OFS_PULSE_BASE = 4'h2;
  localparam logic [3:0] OFS_PULSE_LAST = 4'h9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PWR_AUX_BYPASS = 7;
  localparam int PWR_EMI_QUIET  = 6;
  localparam int PWR_WDOG       = 4;
  localparam int PWR_FLAG_B     = 3;
  localparam int PWR_FLAG_A     = 2;
  localparam int PWR_DOWN       = 1;
  localparam int PWR_IDLE       = 0;

  localparam int ST_CARRY       = 7;
  localparam int ST_AUX_CARRY   = 6;
  localparam int ST_USER_FLAG   = 5;
  localparam int ST_BANK_HI     = 4;
  localparam int ST_BANK_LO     = 3;
  localparam int ST_OVERFLOW    = 2;
  localparam int ST_PARITY      = 0;

  localparam int PULSE_EN       = 7;
  localparam int PULSE_VAL_HI   = 5;
  localparam int PHASE_W        = 6;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] POWER_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PULSE_RESET  = 8'h00;
  localparam logic [7:0] POWER_STORE  = 8'hDC;
  localparam logic [7:0] STATUS_STORE = 8'hFE;
  localparam logic [7:0] PULSE_STORE  = 8'hBF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 10;
  localparam int PULSE_STEP_NS      = 40;
  localparam int PULSE_STEP_CYCLES  = (PULSE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STEP_LAST  = 8'(PULSE_STEP_CYCLES - 1);

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE_ST,
    PWR_DOWN_ST
  } spp_power_e;

  // Keeps stored bits where the mask is set and reads zero elsewhere
  function automatic logic [7:0] spp_store(input logic [7:0] data, input logic [7:0] mask);
    spp_store = data & mask;
  endfunction

endpackage

/* rtl/spp_pulse_if.sv */
// Interface carrying one pulse channel's setting and the shared phase
`timescale 1ns/1ps
interface spp_pulse_if;
  logic       enable;
  logic [5:0] high_time;
  logic [5:0] phase;
  logic       halt;

  modport ctrl (output enable, output high_time, output phase, output halt);
  modport chan (input enable, input high_time, input phase, input halt);
endinterface

/* rtl/spp_pulse_chan.sv */
// One pulse width channel: high while the shared phase is below its high time
`timescale 1ns/1ps
module spp_pulse_chan (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  spp_pulse_if.chan  cfg,
  output logic       pulse_out
);

  wire active;
  wire in_high;

  assign active  = cfg.enable & ~cfg.halt;     // [RL7]
  assign in_high = cfg.phase < cfg.high_time;  // [RL8] [RL9]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= active & in_high;  // [RL7]
    end
  end

endmodule

/* rtl/spp_mem_steer.sv */
// Memory steering: external move routing, latch strobe gating and bank address
`timescale 1ns/1ps
module spp_mem_steer #(
  parameter int AUX_RAM_SIZE = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        aux_ram_bypass,
  input  wire logic        emi_quiet_latch,
  input  wire logic [1:0]  bank_select,
  input  wire logic        xmove_req,
  input  wire logic [15:0] xmove_addr,
  input  wire logic        ale_req,
  input  wire logic        access_internal,
  input  wire logic [2:0]  reg_index,
  output logic             aux_ram_sel,
  output logic             ext_mem_sel,
  output logic             ale_out,
  output logic [7:0]       reg_ram_addr
);

  localparam logic [16:0] AUX_LIMIT = 17'(AUX_RAM_SIZE);

  wire       in_aux;
  wire       next_aux;
  wire       next_ale;
  wire [7:0] next_reg_addr;

  assign in_aux        = {1'b0, xmove_addr} < AUX_LIMIT;
  assign next_aux      = xmove_req & in_aux & ~aux_ram_bypass;          // [RL1]
  assign next_ale      = ale_req & ~(emi_quiet_latch & access_internal); // [RL2]
  assign next_reg_addr = {3'h0, bank_select, reg_index};                // [RL6]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aux_ram_sel  <= 1'b0;
      ext_mem_sel  <= 1'b0;
      ale_out      <= 1'b0;
      reg_ram_addr <= 8'h00;
    end else begin
      aux_ram_sel  <= next_aux;
      ext_mem_sel  <= xmove_req & ~next_aux;  // [RL1]
      ale_out      <= next_ale;
      reg_ram_addr <= next_reg_addr;
    end
  end

endmodule

/* rtl/spp_sfr_top.sv */
// Power control, program status word and eight pulse width channel registers
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps

// How it works
// RL1: With the aux RAM bypass bit set every external move access goes to external memory, never to on-chip aux RAM.
// RL2: With the quiet latch bit set the address latch strobe is suppressed for accesses to internal memory.
// RL3: Writing one to the power-down request bit puts the device into power-down mode.
// RL4: Writing one to the idle request bit puts the device into idle mode.
// RL5: The status word holds a user flag that software writes and reads back with no other effect.
// RL6: The two bank select bits place R0 to R7 at 00H, 08H, 10H or 18H of internal RAM.
// RL7: Each of the eight pulse channels drives output only while its own enable bit is one.
// RL8: Each pulse channel takes its high time from bits five to zero of its own control register.
// RL9: Each enabled channel repeats every 64 steps, high for the programmed steps and low for the rest.
// RL10: The watchdog bit starts the watchdog when set and the aux bypass, quiet latch and two flag bits hold what software wrote.
module spp_sfr_top #(
  parameter int AUX_RAM_SIZE = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        alu_flags_we,
  input  wire logic        alu_carry,
  input  wire logic        alu_aux_carry,
  input  wire logic        alu_overflow,
  input  wire logic [7:0]  acc_value,
  input  wire logic        idle_wake,
  input  wire logic        power_down_wake,
  input  wire logic        xmove_req,
  input  wire logic [15:0] xmove_addr,
  input  wire logic        ale_req,
  input  wire logic        access_internal,
  input  wire logic [2:0]  reg_index,
  output logic             aux_ram_sel,
  output logic             ext_mem_sel,
  output logic             ale_out,
  output logic      [7:0]  reg_ram_addr,
  output logic             idle_mode,
  output logic             power_down_mode,
  output logic             watchdog_run,
  output logic      [7:0]  pulse_out
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0]          power_control;
  logic [7:0]          program_status_word;
  logic [7:0]          pulse_ctrl [spp_pkg::NUM_CH];
  spp_pkg::spp_power_e power_state;
  spp_pkg::spp_power_e next_power_state;
  logic [7:0]          step_count;
  logic [5:0]          phase;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire       hit_power;
  wire       hit_status;
  wire       hit_pulse;
  wire [3:0] pulse_off;
  wire [2:0] pulse_idx;
  wire       wr_power;
  wire       wr_status;
  wire       wr_pulse;

  // True when the address falls inside one register window, both ends included
  function automatic logic addr_in(input logic [3:0] addr, input logic [3:0] first, input logic [3:0] last);
    addr_in = (addr >= first) && (addr <= last);
  endfunction

  assign hit_power  = addr_in(reg_addr, spp_pkg::OFS_POWER, spp_pkg::OFS_POWER);
  assign hit_status = addr_in(reg_addr, spp_pkg::OFS_STATUS, spp_pkg::OFS_STATUS);
  assign hit_pulse  = addr_in(reg_addr, spp_pkg::OFS_PULSE_BASE, spp_pkg::OFS_PULSE_LAST);
  assign pulse_off  = reg_addr - spp_pkg::OFS_PULSE_BASE;
  assign pulse_idx  = pulse_off[2:0];
  assign wr_power   = reg_wr & hit_power;
  assign wr_status  = reg_wr & hit_status;
  assign wr_pulse   = reg_wr & hit_pulse;

  // ****************************************************************
  // Power control
  // ****************************************************************
  wire       req_down;
  wire       req_idle;
  wire [7:0] power_wr_val;

  assign req_down     = wr_power & reg_wdata[spp_pkg::PWR_DOWN];  // [RL3]
  assign req_idle     = wr_power & reg_wdata[spp_pkg::PWR_IDLE];  // [RL4]
  assign power_wr_val = spp_pkg::spp_store(reg_wdata, spp_pkg::POWER_STORE);  // [RL10]

  // A request in the same cycle as a wake wins, except an idle request in power-down, which is ignored
  always_comb begin
    next_power_state = power_state;
    case (power_state)
      spp_pkg::PWR_RUN: begin
        if (req_down) begin
          next_power_state = spp_pkg::PWR_DOWN_ST;  // [RL3]
        end else if (req_idle) begin
          next_power_state = spp_pkg::PWR_IDLE_ST;  // [RL4]
        end
      end
      spp_pkg::PWR_IDLE_ST: begin
        if (req_down) begin
          next_power_state = spp_pkg::PWR_DOWN_ST;  // [RL3]
        end else if (!req_idle && idle_wake) begin
          next_power_state = spp_pkg::PWR_RUN;
        end
      end
      spp_pkg::PWR_DOWN_ST: begin
        if (!req_down && power_down_wake) begin
          next_power_state = spp_pkg::PWR_RUN;
        end
      end
      default: begin
        next_power_state = spp_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_state <= spp_pkg::PWR_RUN;
    end else begin
      power_state <= next_power_state;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_control <= spp_pkg::POWER_RESET;
    end else if (wr_power) begin
      power_control <= power_wr_val;  // [RL10]
    end
  end

  // ****************************************************************
  // Program status word
  // ****************************************************************
  wire [7:0] status_view;
  wire [7:0] status_wr_val;

  assign status_wr_val = spp_pkg::spp_store(reg_wdata, spp_pkg::STATUS_STORE);  // [RL5] [RL6]

  // Software write takes precedence over an ALU flag update in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      program_status_word <= spp_pkg::STATUS_RESET;
    end else if (wr_status) begin
      program_status_word <= status_wr_val;  // [RL5] [RL6]
    end else if (alu_flags_we) begin
      program_status_word[spp_pkg::ST_CARRY]     <= alu_carry;
      program_status_word[spp_pkg::ST_AUX_CARRY] <= alu_aux_carry;
      program_status_word[spp_pkg::ST_OVERFLOW]  <= alu_overflow;
    end
  end

  // Parity follows the accumulator and cannot be written
  assign status_view = {program_status_word[7:1], ^acc_value};

  // ****************************************************************
  // Pulse channel registers and shared phase
  // ****************************************************************
  wire step_tick;
  wire halted;

  assign halted    = power_state == spp_pkg::PWR_DOWN_ST;
  assign step_tick = step_count == spp_pkg::STEP_LAST;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < spp_pkg::NUM_CH; i++) begin
        pulse_ctrl[i] <= spp_pkg::PULSE_RESET;
      end
    end else if (wr_pulse) begin
      pulse_ctrl[pulse_idx] <= spp_pkg::spp_store(reg_wdata, spp_pkg::PULSE_STORE);
    end
  end

  wire [7:0] next_step_count;
  wire [5:0] next_phase;

  // Six phase bits wrap by themselves, giving the 64-step period
  assign next_step_count = step_tick ? 8'h00 : step_count + 8'h01;
  assign next_phase      = step_tick ? phase + 6'h01 : phase;  // [RL9]

  // Both counters freeze in power-down so the waveform resumes where it stopped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      step_count <= 8'h00;
    end else if (!halted) begin
      step_count <= next_step_count;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase <= 6'h00;
    end else if (!halted) begin
      phase <= next_phase;
    end
  end

  spp_pulse_if pulse_bus [spp_pkg::NUM_CH] ();

  for (genvar g = 0; g < spp_pkg::NUM_CH; g++) begin : gen_ch
    assign pulse_bus[g].enable    = pulse_ctrl[g][spp_pkg::PULSE_EN];        // [RL7]
    assign pulse_bus[g].high_time = pulse_ctrl[g][spp_pkg::PULSE_VAL_HI:0];  // [RL8]
    assign pulse_bus[g].phase     = phase;
    assign pulse_bus[g].halt      = halted;

    spp_pulse_chan u_chan (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .cfg       (pulse_bus[g]),
      .pulse_out (pulse_out[g])
    );
  end

  // ****************************************************************
  // Memory steering
  // ****************************************************************
  spp_mem_steer #(
    .AUX_RAM_SIZE (AUX_RAM_SIZE)
  ) u_steer (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .aux_ram_bypass  (power_control[spp_pkg::PWR_AUX_BYPASS]),
    .emi_quiet_latch (power_control[spp_pkg::PWR_EMI_QUIET]),
    .bank_select     (program_status_word[spp_pkg::ST_BANK_HI:spp_pkg::ST_BANK_LO]),
    .xmove_req       (xmove_req),
    .xmove_addr      (xmove_addr),
    .ale_req         (ale_req),
    .access_internal (access_internal),
    .reg_index       (reg_index),
    .aux_ram_sel     (aux_ram_sel),
    .ext_mem_sel     (ext_mem_sel),
    .ale_out         (ale_out),
    .reg_ram_addr    (reg_ram_addr)
  );

  // ****************************************************************
  // Read path and status outputs
  // ****************************************************************
  logic [7:0] next_rdata;
  wire  [7:0] power_view;
  wire        state_idle;
  wire        next_idle;
  wire        next_down;

  assign state_idle = power_state == spp_pkg::PWR_IDLE_ST;
  assign next_idle  = next_power_state == spp_pkg::PWR_IDLE_ST;  // [RL4]
  assign next_down  = next_power_state == spp_pkg::PWR_DOWN_ST;  // [RL3]

  // Bits one and zero read the live state rather than a stored request
  assign power_view = power_control | {6'h00, halted, state_idle};

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (hit_power) begin
        next_rdata = power_view;
      end else if (hit_status) begin
        next_rdata = status_view;  // [RL5]
      end else if (hit_pulse) begin
        next_rdata = pulse_ctrl[pulse_idx];
      end
    end
  end

  // Read data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Mode outputs follow the next state so they rise at the request edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_mode       <= 1'b0;
      power_down_mode <= 1'b0;
    end else begin
      idle_mode       <= next_idle;  // [RL4]
      power_down_mode <= next_down;  // [RL3]
    end
  end

  // Watchdog run follows the stored bit one cycle after the register changes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      watchdog_run <= 1'b0;
    end else begin
      watchdog_run <= power_control[spp_pkg::PWR_WDOG];  // [RL10]
    end
  end

endmodule

/* dv/spp_sfr_props.sv */
// Concurrent checks on the ports of the power, status and pulse register block
`timescale 1ns/1ps
module spp_sfr_props #(
  parameter int AUX_RAM_SIZE = 256
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        power_down_wake,
  input wire logic        xmove_req,
  input wire logic [15:0] xmove_addr,
  input wire logic        ale_req,
  input wire logic [2:0]  reg_index,
  input wire logic        aux_ram_sel,
  input wire logic        ale_out,
  input wire logic [7:0]  reg_ram_addr,
  input wire logic        idle_mode,
  input wire logic        power_down_mode,
  input wire logic        watchdog_run,
  input wire logic [7:0]  pulse_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // Power requests
  // ****************************************************************
  sequence pwr_wr_s;
    reg_wr && reg_addr == spp_pkg::OFS_POWER;
  endsequence
  sequence pwrdn_req_s;
    pwr_wr_s ##0 reg_wdata[spp_pkg::PWR_DOWN];
  endsequence
  sequence idle_req_s;
    pwr_wr_s ##0 reg_wdata[spp_pkg::PWR_IDLE];
  endsequence
  pwrdn_enter_a: assert property (pwrdn_req_s |=> power_down_mode) else $error("power-down not entered");
  pwrdn_hold_a: assert property (power_down_mode && !power_down_wake |=> power_down_mode)
    else $error("power-down left without wake");
  pwrdn_silence_a: assert property (power_down_mode |=> pulse_out == 8'h00)
    else $error("pulse active in power-down");
  idle_enter_a: assert property (idle_req_s |=> idle_mode || power_down_mode)
    else $error("idle not entered");
  watchdog_follow_a: assert property (pwr_wr_s |-> ##2 watchdog_run == $past(reg_wdata[spp_pkg::PWR_WDOG], 2))
    else $error("watchdog run differs from bit");
  // ****************************************************************
  // Steering and read port
  // ****************************************************************
  aux_route_a: assert property (aux_ram_sel |-> $past(xmove_req) && $past(xmove_addr) < AUX_RAM_SIZE)
    else $error("aux RAM chosen without cause");
  ale_gate_a: assert property (ale_out |-> $past(ale_req)) else $error("latch strobe without request");
  bank_addr_a: assert property (1 |=> reg_ram_addr[2:0] == $past(reg_index) && reg_ram_addr[7:5] == 3'h0)
    else $error("working register address wrong");
  rdata_quiet_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
endmodule
bind spp_sfr_top spp_sfr_props #(.AUX_RAM_SIZE(AUX_RAM_SIZE)) spp_sfr_props_inst (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down_wake(power_down_wake), .xmove_req(xmove_req),
  .xmove_addr(xmove_addr), .ale_req(ale_req), .reg_index(reg_index), .aux_ram_sel(aux_ram_sel),
  .ale_out(ale_out), .reg_ram_addr(reg_ram_addr), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
  .watchdog_run(watchdog_run), .pulse_out(pulse_out)
);

/* dv/tb.sv */
// Self-checking bench for the power, status and pulse register block
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, alu_flags_we = 1'b0;
  logic        alu_carry = 1'b0, alu_aux_carry = 1'b0, alu_overflow = 1'b0, idle_wake = 1'b0;
  logic        power_down_wake = 1'b0, xmove_req = 1'b0, ale_req = 1'b0, access_internal = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, acc_value = 8'h00;
  logic [15:0] xmove_addr = 16'h0000;
  logic [2:0]  reg_index = 3'h0;
  logic [7:0]  reg_rdata, reg_ram_addr, pulse_out, d, f;
  logic        aux_ram_sel, ext_mem_sel, ale_out, idle_mode, power_down_mode, watchdog_run, byp, qt, intl;
  logic [15:0] xa;
  logic [7:0]  pv [8];
  logic [7:0]  pc [3] = '{8'h80, 8'hBF, 8'h3F};
  int          cnt [8];
  int          n_fail = 0, n_compared = 0, seed = 32'h161B5BC7;

  always #5 clk_sys = ~clk_sys;

  spp_sfr_top spp_sfr_top_inst (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_flags_we(alu_flags_we), .alu_carry(alu_carry),
    .alu_aux_carry(alu_aux_carry), .alu_overflow(alu_overflow), .acc_value(acc_value),
    .idle_wake(idle_wake), .power_down_wake(power_down_wake), .xmove_req(xmove_req),
    .xmove_addr(xmove_addr), .ale_req(ale_req), .access_internal(access_internal), .reg_index(reg_index),
    .aux_ram_sel(aux_ram_sel), .ext_mem_sel(ext_mem_sel), .ale_out(ale_out), .reg_ram_addr(reg_ram_addr),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode), .watchdog_run(watchdog_run),
    .pulse_out(pulse_out)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
    n_compared++;
    if (seen !== expd) begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] expd);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, expd, "read data");
  endtask
  function automatic logic [7:0] exp_high(input logic [7:0] v);
    exp_high = v[spp_pkg::PULSE_EN] ? 8'(v[5:0]) * 8'(spp_pkg::PULSE_STEP_CYCLES) : 8'h00;
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 10; a++) rd_chk(4'(a), 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hFC : 8'($random(seed)) & 8'hFC;
      wr(spp_pkg::OFS_POWER, d);
      step(1);
      check(8'(watchdog_run), 8'(d[spp_pkg::PWR_WDOG]), "watchdog run");
      rd_chk(spp_pkg::OFS_POWER, d & spp_pkg::POWER_STORE);
    end
    wr(spp_pkg::OFS_POWER, 8'h00);
    $display("test power bits done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[4:3] = 2'(i);
      wr(spp_pkg::OFS_STATUS, d);
      @(posedge clk_sys);
      acc_value <= 8'($random(seed));
      reg_index <= 3'($random(seed));
      #1;
      rd_chk(spp_pkg::OFS_STATUS, (d & spp_pkg::STATUS_STORE) | 8'(^acc_value));
      check(reg_ram_addr, {3'h0, d[4:3], reg_index}, "bank address");
      f = 8'($random(seed));
      @(posedge clk_sys);
      alu_flags_we <= 1'b1;
      {alu_carry, alu_aux_carry, alu_overflow} <= f[2:0];
      @(posedge clk_sys);
      alu_flags_we <= 1'b0;
      rd_chk(spp_pkg::OFS_STATUS, {f[2], f[1], d[5:3], f[0], d[1], ^acc_value});
    end
    $display("test status word done");
    for (int i = 0; i < 8; i++) begin
      byp = 1'(i % 2);
      qt = 1'(i / 2 % 2);
      xa = (i < 2) ? 16'h00FF + 16'(i) : 16'(9'($random(seed)));
      intl = 1'($random(seed));
      wr(spp_pkg::OFS_POWER, {byp, qt, 6'h00});
      xmove_req <= 1'b1;
      xmove_addr <= xa;
      ale_req <= 1'b1;
      access_internal <= intl;
      step(1);
      check(8'(aux_ram_sel), 8'(!byp && xa < 16'h0100), "aux select");
      check(8'(ext_mem_sel), 8'(byp || xa >= 16'h0100), "external select");
      check(8'(ale_out), 8'(!(qt && intl)), "latch strobe");
      xmove_req <= 1'b0;
      ale_req <= 1'b0;
    end
    wr(spp_pkg::OFS_POWER, 8'h00);
    $display("test steering done");
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 8; c++) begin
        pv[c] = (r == 0 && c < 3) ? pc[c] : 8'($random(seed));
        wr(4'(2 + c), pv[c]);
        rd_chk(4'(2 + c), pv[c] & spp_pkg::PULSE_STORE);
        cnt[c] = 0;
      end
      step(8);
      repeat (64 * spp_pkg::PULSE_STEP_CYCLES) begin
        step(1);
        for (int c = 0; c < 8; c++) cnt[c] += int'(pulse_out[c]);
      end
      for (int c = 0; c < 8; c++) check(8'(cnt[c]), exp_high(pv[c]), "high cycles");
    end
    $display("test pulse channels done");
    wr(spp_pkg::OFS_POWER, 8'h01);
    check(8'(idle_mode), 8'h01, "idle entry");
    rd_chk(spp_pkg::OFS_POWER, 8'h01);
    idle_wake <= 1'b1;
    step(1);
    idle_wake <= 1'b0;
    check(8'(idle_mode), 8'h00, "idle exit");
    wr(4'h2, 8'hBF);
    wr(spp_pkg::OFS_POWER, 8'h02);
    check(8'(power_down_mode), 8'h01, "power-down entry");
    step(2);
    check(pulse_out, 8'h00, "pulses in power-down");
    wr(spp_pkg::OFS_POWER, 8'h00);
    check(8'(power_down_mode), 8'h01, "power-down held");
    power_down_wake <= 1'b1;
    step(1);
    power_down_wake <= 1'b0;
    check(8'(power_down_mode), 8'h00, "power-down exit");
    $display("test reduced power done");
    for (int a = 10; a < 16; a++) begin
      wr(4'(a), 8'hFF);
      rd_chk(4'(a), 8'h00);
    end
    $display("test unmapped done");
    give_verdict();
  end
endmodule
